// >>> inc/smbts_defines.svh
`ifndef SMBTS_DEFINES_SVH
`define SMBTS_DEFINES_SVH
// =====================================================================
// Register indices (byte address is four times the index)
`define SMBTS_IDX_CTRL  8'hC0
`define SMBTS_IDX_CFG   8'hC1
`define SMBTS_IDX_DATA  8'hC2
`define SMBTS_IDX_ADDR  8'hC7
`define SMBTS_IDX_MASK  8'hCF
// =====================================================================
// Field positions of serial_control_status
`define SMBTS_B_MASTER  7
`define SMBTS_B_TRANSMIT_DIRECTION_FLAG  6
`define SMBTS_B_STA     5
`define SMBTS_B_STO     4
`define SMBTS_B_ACK_REQUEST_FLAG   3
`define SMBTS_B_ARBLOST 2
`define SMBTS_B_ACK     1
`define SMBTS_B_SI      0
// Field positions of configuration, mask and own address
`define SMBTS_B_EN      0
`define SMBTS_B_INH     1
`define SMBTS_B_TXERR   7
`define SMBTS_B_AUTOACK 0
`define SMBTS_B_GC      0
// =====================================================================
// Reset values
`define SMBTS_MASK_RST  8'hFE
// =====================================================================
// Timing
`define SMBTS_CLK_NS       5
`define SMBTS_SCL_HALF_NS  5000
`define SMBTS_SCL_HALF_CYC ((`SMBTS_SCL_HALF_NS + `SMBTS_CLK_NS - 1) / `SMBTS_CLK_NS)
`define SMBTS_BITS         4'h8
`endif

// >>> inc/smbts_pkg.sv
package smbts_pkg;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_START = 3'h1,
      ST_HOLD  = 3'h3,
      ST_SHIFT = 3'h2,
      ST_ACK   = 3'h6,
      ST_STOP  = 3'h7
   } smbts_state_t;

   typedef struct packed {
      smbts_state_t st;
      logic [1:0]   phase;
      logic [3:0]   bitcnt;
      logic [7:0]   sbuf;
      logic         master;
      logic         transmit_direction_flag;
      logic         start_request;
      logic         stop_request;
      logic         ack_request_flag;
      logic         arblost;
      logic         ack;
      logic         si;
      logic         en;
      logic         slave_inhibit;
      logic         txerr;
      logic [7:0]   own;
      logic [7:0]   mask;
      logic         data_wr;
      logic         addr_ph;
      logic         nack_end;
      logic         busy;
      logic         scl_low;
      logic         sda_low;
      logic [15:0]  div;
      logic         pready;
      logic         pslverr;
      logic [7:0]   prd;
   } smbts_regs_t;

   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
      logic [1:0] s3;
   } smbts_sync_t;
endpackage : smbts_pkg

// >>> inc/smbts_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface smbts_bus_if;
   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   modport src  (output scl, sda, scl_rise, scl_fall, start_det, stop_det);
   modport sink (input  scl, sda, scl_rise, scl_fall, start_det, stop_det);
endinterface : smbts_bus_if
`default_nettype wire

// >>> verilog/smbts_sync.sv
`timescale 1ns/1ps
`default_nettype none
module smbts_sync
   import smbts_pkg::*;
(
   input  wire logic clk_sys,   // System clock
   input  wire logic rst,       // Asynchronous reset, active high
   input  wire logic scl_pin,   // Raw SCL level
   input  wire logic sda_pin,   // Raw SDA level
   smbts_bus_if.src  bus        // Clean levels and bus events
);
   smbts_sync_t q;
   smbts_sync_t n;

   always_comb begin
      n    = q;
      n.s1 = {sda_pin, scl_pin};
      n.s2 = q.s1;
      n.s3 = q.s2;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         q <= '1;
      end else begin
         q <= n;
      end
   end

   // Events look at the second and third stages only
   assign bus.scl       = q.s2[0];
   assign bus.sda       = q.s2[1];
   assign bus.scl_rise  = q.s2[0] & ~q.s3[0];
   assign bus.scl_fall  = ~q.s2[0] & q.s3[0];
   assign bus.start_det = q.s2[0] & q.s3[0] & ~q.s2[1] & q.s3[1];
   assign bus.stop_det  = q.s2[0] & q.s3[0] & q.s2[1] & ~q.s3[1];
endmodule : smbts_sync
`default_nettype wire

// >>> verilog/smbts_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "smbts_defines.svh"
// Behaviour
// - One 8-bit buffer for sent or received byte
// - Buffer write only while byte-done flag set
// - START enters master; arbitration loss or STOP leaves
// - Byte-done flag set after every byte frame except an auto-NACKed address
// - Receive flag before ACK manual, after automatic
// - Transmit flag after the ACK cycle, and after START
// - Master write sends address with direction zero
// - Stop request ends master transfer with STOP
// - No buffer write after master send: receive
// - Master read drives SCL, slave sends data
// - Manual ack: set ack request, wait software
// - Automatic ack uses preset ack bit first
// - Ack bit one gives ACK, zero NACK
// - Master receiver leaves on STOP, write switches
// - Slave receive on START plus address uninhibited
// - Manual ack: software accepts or ignores address
// - Automatic ack answers matching slave address
// - NACKed address mutes slave until next START
// - Slave receiver leaves on STOP, write switches
// - Slave transmitter samples ACK, flags late write
// - Slave transmitter leaves on STOP, else receives
// - Upper four status bits form the status vector
// - Shift MSB first, buffer holds last byte
// - Auto-ack bit picks firmware or hardware ack
module smbts_top
   import smbts_pkg::*;
#(
   parameter int HALF_CYC = `SMBTS_SCL_HALF_CYC  // System cycles per SCL half period
) (
   input  wire logic        clk_sys,   // System clock, 200 MHz
   input  wire logic        rst,       // Asynchronous reset, active high
   input  wire logic        psel,      // APB select
   input  wire logic        penable,   // APB enable
   input  wire logic        pwrite,    // APB direction
   input  wire logic [31:0] paddr,     // APB byte address
   input  wire logic [31:0] pwdata,    // APB write data
   output var  logic [31:0] prdata,    // APB read data
   output var  logic        pready,    // APB ready
   output var  logic        pslverr,   // APB error, unmapped address
   input  wire logic        scl_in,    // SCL pin level
   output var  logic        scl_out,   // SCL output value, always low
   output var  logic        scl_oe_n,  // SCL pull-down, low while driving
   input  wire logic        sda_in,    // SDA pin level
   output var  logic        sda_out,   // SDA output value, always low
   output var  logic        sda_oe_n   // SDA pull-down, low while driving
);
   localparam logic [15:0] HALF_M1 = 16'(HALF_CYC - 1);

   smbts_regs_t q;
   smbts_regs_t n;
   smbts_bus_if bus ();
   logic        tick;
   logic        gen_on;
   logic        acc;
   logic        wr_go;
   logic        hit;
   logic [7:0]  idx;
   logic [7:0]  rd_val;

   smbts_sync u_sync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .scl_pin (scl_in),
      .sda_pin (sda_in),
      .bus     (bus.src)
   );

   // ==================================================================
   // Helpers
   function automatic logic addr_match(input logic [7:0] b, input logic [7:0] own,
                                       input logic [7:0] msk);
      return (((b[7:1] ^ own[7:1]) & msk[7:1]) == 7'h00) ||
             (own[`SMBTS_B_GC] && (b[7:1] == 7'h00));
   endfunction : addr_match

   // Continue after a finished byte: STOP, repeated START, mute or next byte
   function automatic smbts_regs_t next_byte(input smbts_regs_t r);
      r.bitcnt  = 4'h0;
      r.addr_ph = 1'b0;
      r.sda_low = 1'b0;
      if (r.master && r.stop_request) begin
         r.st      = ST_STOP;
         r.phase   = 2'h0;
         r.sda_low = 1'b1;
         r.scl_low = 1'b1;
      end else if (r.master && r.start_request) begin
         r.st    = ST_START;
         r.phase = 2'h0;
      end else if (r.nack_end) begin
         r.st       = ST_IDLE;
         r.nack_end = 1'b0;
         r.transmit_direction_flag   = 1'b0;
         r.scl_low  = 1'b0;
      end else begin
         r.st      = ST_SHIFT;
         r.transmit_direction_flag  = r.data_wr;
         r.sda_low = r.data_wr & ~r.sbuf[7];
         r.scl_low = r.master;
      end
      r.data_wr = 1'b0;
      return r;
   endfunction : next_byte

   // ==================================================================
   // Register decode
   assign idx = paddr[9:2];
   always_comb begin
      hit = (paddr[1:0] == 2'h0) && (paddr[31:10] == 22'h000000) &&
            (idx == `SMBTS_IDX_CTRL || idx == `SMBTS_IDX_CFG || idx == `SMBTS_IDX_DATA ||
             idx == `SMBTS_IDX_ADDR || idx == `SMBTS_IDX_MASK);
      rd_val = 8'h00;
      case (idx)
         `SMBTS_IDX_CTRL: begin
            rd_val = {q.master, q.transmit_direction_flag, q.start_request, q.stop_request, q.ack_request_flag, q.arblost, q.ack, q.si};
         end
         `SMBTS_IDX_CFG: begin
            rd_val[`SMBTS_B_EN]    = q.en;
            rd_val[`SMBTS_B_INH]   = q.slave_inhibit;
            rd_val[`SMBTS_B_TXERR] = q.txerr;
         end
         `SMBTS_IDX_DATA: rd_val = q.sbuf;
         `SMBTS_IDX_ADDR: rd_val = q.own;
         `SMBTS_IDX_MASK: rd_val = q.mask;
         default:         rd_val = 8'h00;
      endcase
   end

   // ==================================================================
   // Next state
   always_comb begin
      n         = q;
      n.pready  = 1'b0;
      n.pslverr = 1'b0;
      acc       = psel & penable;
      wr_go     = acc & q.pready & pwrite;
      gen_on    = (q.st == ST_START) || (q.st == ST_STOP) ||
                  (q.master && (q.st == ST_SHIFT || q.st == ST_ACK));
      tick      = gen_on && (q.div == HALF_M1);
      n.div     = (tick || !gen_on) ? 16'h0000 : q.div + 16'h0001;

      // APB: one wait state, data and error prepared before pready
      if (acc && !q.pready) begin
         n.pready  = 1'b1;
         n.pslverr = ~hit;
         n.prd     = rd_val;
      end
      if (wr_go && hit) begin
         case (idx)
            `SMBTS_IDX_CTRL: begin
               n.start_request     = pwdata[`SMBTS_B_STA];
               n.stop_request     = pwdata[`SMBTS_B_STO];
               n.ack     = pwdata[`SMBTS_B_ACK];
               n.si      = q.si & pwdata[`SMBTS_B_SI];
               n.arblost = q.arblost & pwdata[`SMBTS_B_ARBLOST];
            end
            `SMBTS_IDX_CFG: begin
               n.en    = pwdata[`SMBTS_B_EN];
               n.slave_inhibit   = pwdata[`SMBTS_B_INH];
               n.txerr = 1'b0;
            end
            `SMBTS_IDX_DATA: begin
               if (q.si) begin
                  n.sbuf    = pwdata[7:0];
                  n.data_wr = 1'b1;
                  if (!q.master && q.transmit_direction_flag && !q.ack) begin
                     n.txerr = 1'b1;
                  end
               end
            end
            `SMBTS_IDX_ADDR: n.own  = pwdata[7:0];
            `SMBTS_IDX_MASK: n.mask = pwdata[7:0];
            default: n.own = q.own;
         endcase
      end

      if (bus.start_det) begin
         n.busy = 1'b1;
      end
      if (bus.stop_det) begin
         n.busy = 1'b0;
      end

      // Master clock generator, waits while a slave stretches SCL
      if (q.master && tick && (q.st == ST_SHIFT || q.st == ST_ACK)) begin
         if (q.scl_low) begin
            n.scl_low = 1'b0;
         end else if (bus.scl) begin
            n.scl_low = 1'b1;
         end
      end

      if (!q.en) begin
         n.st      = ST_IDLE;
         n.master  = 1'b0;
         n.transmit_direction_flag  = 1'b0;
         n.scl_low = 1'b0;
         n.sda_low = 1'b0;
      end else begin
         case (q.st)
            ST_IDLE: begin
               n.scl_low = 1'b0;
               n.sda_low = 1'b0;
               if (q.start_request && !q.busy) begin
                  n.st    = ST_START;
                  n.phase = 2'h0;
               end
            end
            ST_START: begin
               if (q.phase == 2'h0) begin
                  n.sda_low = 1'b0;
                  if (tick && q.scl_low) begin
                     n.scl_low = 1'b0;
                  end else if (tick && bus.scl && bus.sda) begin
                     n.sda_low = 1'b1;
                     n.phase   = 2'h1;
                  end
               end else if (tick) begin
                  n.scl_low = 1'b1;
                  n.master  = 1'b1;
                  n.transmit_direction_flag  = 1'b1;
                  n.start_request     = 1'b0;
                  n.si      = 1'b1;
                  n.bitcnt  = 4'h0;
                  n.addr_ph = 1'b1;
                  n.data_wr = 1'b0;
                  n.st      = ST_HOLD;
               end
            end
            ST_SHIFT: begin
               if (bus.scl_rise && q.bitcnt != `SMBTS_BITS) begin
                  n.sbuf   = {q.sbuf[6:0], bus.sda};
                  n.bitcnt = q.bitcnt + 4'h1;
                  if (q.master && q.transmit_direction_flag && !q.sda_low && !bus.sda) begin
                     n.arblost = 1'b1;
                     n.master  = 1'b0;
                     n.transmit_direction_flag  = 1'b0;
                     n.scl_low = 1'b0;
                  end
               end
               if (bus.scl_fall) begin
                  if (q.bitcnt != `SMBTS_BITS) begin
                     n.sda_low = q.transmit_direction_flag & ~q.sbuf[7];
                  end else if (q.transmit_direction_flag) begin
                     n.sda_low = 1'b0;
                     n.st      = ST_ACK;
                  end else if (!q.mask[`SMBTS_B_AUTOACK]) begin
                     n.si      = 1'b1;
                     n.ack_request_flag   = 1'b1;
                     n.scl_low = 1'b1;
                     n.st      = ST_HOLD;
                  end else begin
                     n.st = ST_ACK;
                     if (q.addr_ph && !q.master) begin
                        n.sda_low  = addr_match(q.sbuf, q.own, q.mask);
                        n.nack_end = ~addr_match(q.sbuf, q.own, q.mask);
                     end else begin
                        n.sda_low = q.ack;
                     end
                  end
               end
            end
            ST_ACK: begin
               if (bus.scl_rise) begin
                  if (q.transmit_direction_flag) begin
                     n.ack = ~bus.sda;
                     n.si  = 1'b1;
                  end else if (q.mask[`SMBTS_B_AUTOACK] && !q.nack_end) begin
                     n.si = 1'b1;
                  end
               end
               if (bus.scl_fall) begin
                  n.sda_low = 1'b0;
                  if (q.si) begin
                     n.scl_low = 1'b1;
                     n.st      = ST_HOLD;
                  end else begin
                     n = next_byte(n);
                  end
               end
            end
            ST_HOLD: begin
               n.scl_low = 1'b1;
               if (!q.si) begin
                  if (q.ack_request_flag) begin
                     n.ack_request_flag   = 1'b0;
                     n.st      = ST_ACK;
                     n.sda_low = q.ack;
                     n.scl_low = q.master;
                     if (q.addr_ph && !q.master && !q.ack) begin
                        n.nack_end = 1'b1;
                     end
                  end else begin
                     n = next_byte(n);
                  end
               end
            end
            ST_STOP: begin
               if (q.phase == 2'h0) begin
                  if (tick) begin
                     n.scl_low = 1'b0;
                     n.phase   = 2'h1;
                  end
               end else if (tick && bus.scl) begin
                  n.sda_low = 1'b0;
                  n.master  = 1'b0;
                  n.stop_request     = 1'b0;
                  n.transmit_direction_flag  = 1'b0;
                  n.st      = ST_IDLE;
               end
            end
            default: n.st = ST_IDLE;
         endcase

         // Slave side: STOP ends, START restarts address reception
         if (!q.master && q.st != ST_START && q.st != ST_STOP) begin
            if (bus.stop_det) begin
               n.st       = ST_IDLE;
               n.transmit_direction_flag   = 1'b0;
               n.nack_end = 1'b0;
               n.scl_low  = 1'b0;
               n.sda_low  = 1'b0;
            end else if (bus.start_det && !q.slave_inhibit) begin
               n.st       = ST_SHIFT;
               n.transmit_direction_flag   = 1'b0;
               n.bitcnt   = 4'h0;
               n.addr_ph  = 1'b1;
               n.nack_end = 1'b0;
               n.data_wr  = 1'b0;
               n.scl_low  = 1'b0;
               n.sda_low  = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         q      <= '0;
         q.mask <= `SMBTS_MASK_RST;
      end else begin
         q <= n;
      end
   end

   assign prdata   = {24'h000000, q.prd};
   assign pready   = q.pready;
   assign pslverr  = q.pslverr;
   assign scl_out  = 1'b0;
   assign sda_out  = 1'b0;
   assign scl_oe_n = ~q.scl_low;
   assign sda_oe_n = ~q.sda_low;

   // ==================================================================
   // Assertions
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   a_hold_scl_low: assert property ((q.st == ST_HOLD && q.si) |-> !scl_oe_n)
      else $error("SCL released while byte-done flag set");
   a_start_master: assert property ($rose(q.master) |->
         $past(q.st) == ST_START && q.si && q.transmit_direction_flag)
      else $error("Master entered without START");
   a_stop_leaves: assert property ($fell(q.master) |->
         q.arblost || ($past(q.st) == ST_STOP && q.st == ST_IDLE && !q.stop_request))
      else $error("Master left without STOP or lost arbitration");
   a_msb_first: assert property ((q.en && q.st == ST_SHIFT && q.transmit_direction_flag && bus.scl_fall &&
         q.bitcnt != `SMBTS_BITS && !bus.start_det && !bus.stop_det) |=>
         q.sda_low == !$past(q.sbuf[7]))
      else $error("Transmit bit is not buffer MSB");
   a_shift_in: assert property ((q.en && q.st == ST_SHIFT && bus.scl_rise &&
         q.bitcnt != `SMBTS_BITS && !bus.start_det && !bus.stop_det) |=>
         q.sbuf[0] == $past(bus.sda) && q.bitcnt == $past(q.bitcnt) + 4'h1)
      else $error("Received bit not shifted into buffer");
   a_rx_early_si: assert property ($rose(q.ack_request_flag) |->
         q.si && !q.mask[`SMBTS_B_AUTOACK] && !q.transmit_direction_flag && q.st == ST_HOLD)
      else $error("Ack request without early flag");
   a_tx_late_si: assert property (($rose(q.si) && q.transmit_direction_flag && q.st != ST_HOLD) |->
         $past(q.st) == ST_ACK && $past(bus.scl_rise))
      else $error("Transmit flag not after ACK");
   a_auto_ack: assert property ((q.en && q.st == ST_SHIFT && q.bitcnt == `SMBTS_BITS &&
         bus.scl_fall && !q.transmit_direction_flag && q.mask[`SMBTS_B_AUTOACK] && !q.addr_ph &&
         !bus.start_det && !bus.stop_det) |=> q.st == ST_ACK && q.sda_low == $past(q.ack))
      else $error("Automatic ack does not follow ack bit");
   a_mode_pick: assert property ((q.st == ST_SHIFT && $past(q.st) == ST_HOLD &&
         !$past(bus.start_det)) |-> q.transmit_direction_flag == $past(q.data_wr))
      else $error("Direction not taken from buffer write");
   a_mute_nack: assert property ($rose(q.si) |-> !$past(q.nack_end))
      else $error("Slave flag after ignored address");
   a_apb_ready: assert property (q.pready |=> !q.pready)
      else $error("pready held longer than one cycle");

   c_master_start: cover property ($rose(q.master));
   c_arb_lost:     cover property ($rose(q.arblost));
   c_slave_addr:   cover property ($rose(q.si) && !q.master && q.addr_ph);
   c_stop_done:    cover property (q.st == ST_STOP ##1 q.st == ST_IDLE);
endmodule : smbts_top
`default_nettype wire

// >>> test/smbts_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module smbts_slave_model #(
   parameter logic [7:0] TX_BYTE = 8'hA5  // Byte returned on reads
) (
   input  wire logic       scl,       // SCL wire level
   input  wire logic       sda,       // SDA wire level
   output var  logic       sda_oe_n,  // Low while the model pulls SDA
   output var  logic [7:0] rx_byte,   // Last byte taken from the master
   output var  logic       ack_seen   // Master ack level on last read byte
);
   int         k = 0;
   logic       active = 1'b0;
   logic       addr_ph = 1'b0;
   logic       rd = 1'b0;
   logic [7:0] sh = 8'h00;
   initial begin
      sda_oe_n = 1'b1;
      rx_byte  = 8'h00;
      ack_seen = 1'b0;
   end
   // ==================================================================
   // START opens a frame, STOP closes it
   always @(sda) begin
      if (scl === 1'b1) begin
         active = !sda;
         k = -1;
         addr_ph = 1'b1;
         rd = 1'b0;
         sda_oe_n = 1'b1;
      end
   end
   always @(posedge scl) begin
      if (active && k >= 0 && k < 8) sh = {sh[6:0], sda};
      if (active && k == 8 && rd && !addr_ph) begin
         ack_seen = sda;
         if (sda) active = 1'b0;
      end
   end
   always @(negedge scl) begin
      if (active) begin
         if (k == 8) begin
            k = 0;
            addr_ph = 1'b0;
         end else k = k + 1;
         if (k == 8) begin
            if (addr_ph) rd = sh[0];
            if (addr_ph || !rd) begin
               rx_byte = sh;
               sda_oe_n = 1'b0;
            end else sda_oe_n = 1'b1;
         end else sda_oe_n = (rd && !addr_ph) ? TX_BYTE[7 - k] : 1'b1;
      end
   end
endmodule : smbts_slave_model
`default_nettype wire

// >>> test/smbus_transfer_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "smbts_defines.svh"
module smbus_transfer_sequencer_test;
   localparam int HALF = 8;
   logic        clk_sys = 1'b0;
   logic        rst     = 1'b1;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [31:0] paddr   = 32'h0;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, scl_out, scl_oe_n, sda_out, sda_oe_n, m_sda_oe_n, ack_seen;
   logic [7:0]  rx_byte;
   logic [31:0] v;
   logic        e;
   wire logic   scl_in = scl_oe_n;
   wire logic   sda_in = sda_oe_n & m_sda_oe_n;
   int          miscompares = 0;
   int          checks_done = 0;
   always #2.5 clk_sys = ~clk_sys;
   smbts_top #(.HALF_CYC(HALF)) i_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .scl_in(scl_in), .scl_out(scl_out),
      .scl_oe_n(scl_oe_n), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n));
   smbts_slave_model #(.TX_BYTE(8'hA5)) i_slave (.scl(scl_in), .sda(sda_in),
      .sda_oe_n(m_sda_oe_n), .rx_byte(rx_byte), .ack_seen(ack_seen));
   // ==================================================================
   // Bus tasks
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : tally_and_finish
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      @(posedge clk_sys);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr;
      paddr <= {22'h0, idx, 2'h0}; pwdata <= {24'h0, wd};
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge clk_sys); n++; end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         miscompares++;
         $display("[FAIL] pready expected 1 seen %b", pready);
      end
      rd = prdata; err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
      logic [31:0] r; logic x;
      apb(1'b1, idx, wd, r, x);
   endtask : wr
   task automatic expect_reg(input logic [7:0] idx, input logic [7:0] exp,
                             input logic [7:0] msk, input string what);
      logic [31:0] r; logic x;
      apb(1'b0, idx, 8'h00, r, x);
      check(what, r & {24'h0, msk}, {24'h0, exp & msk});
   endtask : expect_reg
   task automatic wait_si();
      logic [31:0] r; logic x; int n;
      n = 0;
      do begin apb(1'b0, `SMBTS_IDX_CTRL, 8'h00, r, x); n++; end
         while (r[0] !== 1'b1 && n < 400);
      check("byte done", {31'h0, r[0]}, 32'h1);
   endtask : wait_si
   // ==================================================================
   // Tests
   initial begin
      #200000;
      miscompares++;
      $display("[FAIL] watchdog expected done seen timeout");
      tally_and_finish();
   end
   initial begin
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      expect_reg(`SMBTS_IDX_MASK, 8'hFE, 8'hFF, "mask reset");
      expect_reg(`SMBTS_IDX_DATA, 8'h00, 8'hFF, "buffer reset");
      apb(1'b0, 8'h10, 8'h00, v, e);
      check("unmapped error", {31'h0, e}, 32'h1);
      wr(`SMBTS_IDX_CFG, 8'h01);
      wr(`SMBTS_IDX_CTRL, 8'h20);
      wait_si();
      expect_reg(`SMBTS_IDX_CTRL, 8'hC1, 8'hFD, "start status");
      check("scl held", {31'h0, scl_oe_n}, 32'h0);
      wr(`SMBTS_IDX_DATA, 8'hA0); wr(`SMBTS_IDX_CTRL, 8'h00); wait_si();
      expect_reg(`SMBTS_IDX_CTRL, 8'hC3, 8'hFF, "addr acked");
      check("slave addr", {24'h0, rx_byte}, 32'hA0);
      wr(`SMBTS_IDX_DATA, 8'h3C); wr(`SMBTS_IDX_CTRL, 8'h00); wait_si();
      expect_reg(`SMBTS_IDX_CTRL, 8'hC3, 8'hFF, "data acked");
      check("slave data", {24'h0, rx_byte}, 32'h3C);
      wr(`SMBTS_IDX_CTRL, 8'h20); wait_si();
      expect_reg(`SMBTS_IDX_CTRL, 8'hC1, 8'hFD, "restart status");
      wr(`SMBTS_IDX_DATA, 8'hA1); wr(`SMBTS_IDX_CTRL, 8'h00); wait_si();
      expect_reg(`SMBTS_IDX_CTRL, 8'hC3, 8'hFF, "read addr acked");
      wr(`SMBTS_IDX_CTRL, 8'h02); wait_si();
      expect_reg(`SMBTS_IDX_CTRL, 8'h89, 8'hFD, "ack requested");
      expect_reg(`SMBTS_IDX_DATA, 8'hA5, 8'hFF, "byte read");
      wr(`SMBTS_IDX_CTRL, 8'h10);
      repeat (8 * HALF) @(posedge clk_sys);
      check("nack level", {31'h0, ack_seen}, 32'h1);
      expect_reg(`SMBTS_IDX_CTRL, 8'h00, 8'hF1, "idle after stop");
      check("bus idle", {30'h0, scl_in, sda_in}, 32'h3);
      wr(`SMBTS_IDX_MASK, 8'hFF);
      wr(`SMBTS_IDX_CTRL, 8'h22); wait_si();
      wr(`SMBTS_IDX_DATA, 8'hA1); wr(`SMBTS_IDX_CTRL, 8'h02); wait_si();
      wr(`SMBTS_IDX_CTRL, 8'h02); wait_si();
      expect_reg(`SMBTS_IDX_CTRL, 8'h83, 8'hFF, "auto ack status");
      check("ack level", {31'h0, ack_seen}, 32'h0);
      wr(`SMBTS_IDX_CTRL, 8'h10);
      repeat (8 * HALF) @(posedge clk_sys);
      wr(`SMBTS_IDX_DATA, 8'h77);
      expect_reg(`SMBTS_IDX_DATA, 8'hA5, 8'hFF, "write ignored");
      tally_and_finish();
   end
endmodule : smbus_transfer_sequencer_test
`default_nettype wire
